/* design/mio_pkg.sv */
// shared constants of the motion i/o function mapper
package mio_pkg;

  // channel counts and bus widths
  localparam int unsigned IN_COUNT   = 16;
  localparam int unsigned OUT_COUNT  = 8;
  localparam int unsigned AXIS_COUNT = 4;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 32;

  // clock rate and input scan period
  localparam int unsigned CLK_HZ          = 50_000_000;
  localparam int unsigned SCAN_PERIOD_MS  = 2;
  localparam int unsigned SCAN_CYCLES_DEF = (CLK_HZ / 1000) * SCAN_PERIOD_MS;

  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_IN_STATE  = 8'h00;
  localparam logic [ADDR_W-1:0] REG_IN_ACTIVE = 8'h04;
  localparam logic [ADDR_W-1:0] REG_TRIG_KIND = 8'h08;
  localparam logic [ADDR_W-1:0] REG_IN_POL    = 8'h0C;
  localparam logic [ADDR_W-1:0] REG_RISE_SEL  = 8'h10;
  localparam logic [ADDR_W-1:0] REG_FALL_SEL  = 8'h14;
  localparam logic [ADDR_W-1:0] REG_PENDING   = 8'h18;
  localparam logic [ADDR_W-1:0] REG_IRQ_MASK  = 8'h1C;
  localparam logic [ADDR_W-1:0] REG_OUT_MODE  = 8'h20;
  localparam logic [ADDR_W-1:0] REG_OUT_AXES  = 8'h24;
  localparam logic [ADDR_W-1:0] REG_OUT_VALUE = 8'h28;
  localparam logic [ADDR_W-1:0] REG_OUT_POL   = 8'h2C;
  localparam logic [ADDR_W-1:0] REG_AXIS_MAP0 = 8'h30;
  localparam logic [ADDR_W-1:0] REG_AXIS_MAP1 = 8'h34;
  localparam logic [ADDR_W-1:0] REG_AXIS_MAP2 = 8'h38;
  localparam logic [ADDR_W-1:0] REG_AXIS_MAP3 = 8'h3C;

  // per-axis function map: five fields of enable bit plus input index
  localparam int unsigned FN_W      = 5;
  localparam int unsigned FN_IDX_W  = 4;
  localparam int unsigned FN_EN_BIT = 4;
  localparam int unsigned FN_FWD    = 0;
  localparam int unsigned FN_REV    = 5;
  localparam int unsigned FN_HOME   = 10;
  localparam int unsigned FN_ERR    = 15;
  localparam int unsigned FN_STOP   = 20;

  // output source modes, two bits per output
  localparam int unsigned  OMODE_W       = 2;
  localparam logic [1:0]   OMODE_GENERAL = 2'h0;
  localparam logic [1:0]   OMODE_DRIVE   = 2'h1;
  localparam logic [1:0]   OMODE_ERROR   = 2'h2;

  // reset values
  localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

endpackage : mio_pkg

/* design/mio_in_sampler.sv */
`timescale 1ns/1ps
`default_nettype none
// one input channel: synchroniser, scan sample and edge pulses
module mio_in_sampler (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  input  wire logic ce_i,
  // scan strobe
  input  wire logic scan_tick_i,
  // pin
  input  wire logic pin_i,
  // sampled results
  output logic      level_o,
  output logic      rise_o,
  output logic      fall_o
);

  logic sync1_q;  // first stage, read only by second stage
  logic sync2_q;  // settled pin level

  // two flip-flop synchroniser
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (ce_i) begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // level taken once per scan; edges are one-cycle pulses at the scan
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      level_o <= 1'b0;
      rise_o  <= 1'b0;
      fall_o  <= 1'b0;
    end else if (ce_i) begin
      rise_o <= scan_tick_i & sync2_q & ~level_o;
      fall_o <= scan_tick_i & ~sync2_q & level_o;
      if (scan_tick_i) begin
        level_o <= sync2_q;
      end
    end
  end

endmodule : mio_in_sampler
`default_nettype wire

/* design/mio_top.sv */
// What this block does
// [RULE1] sixteen inputs, eight outputs, each bit addressable
// [RULE2] map inputs to per-axis limit, home, error, stop
// [RULE3] several axes may reference one input
// [RULE4] inputs edge or level, selectable polarity
// [RULE5] outputs as axis drive enable or error
// [RULE6] several axes may share one drive-enable output
// [RULE7] programmable output active level inverts drive
// [RULE8] pulses of one 2ms scan are caught
// [RULE9] outputs inactive after reset until reconfigured
// [RULE10] edge inputs set sticky flag until acknowledged
`timescale 1ns/1ps
`default_nettype none
module mio_top
  import mio_pkg::*;
#(
  parameter int unsigned SCAN_CYCLES = SCAN_CYCLES_DEF  // cycles per input scan
) (
  // clock, reset, enable
  input  wire logic                  clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  ce_i,
  // register port
  input  wire logic [ADDR_W-1:0]     addr_i,
  input  wire logic [DATA_W-1:0]     wdata_i,
  input  wire logic                  we_i,
  input  wire logic                  re_i,
  output logic      [DATA_W-1:0]     rdata_o,
  // motion logic sources for outputs
  input  wire logic [AXIS_COUNT-1:0] axis_drive_en_i,
  input  wire logic                  gen_error_i,
  // pins
  input  wire logic [IN_COUNT-1:0]   din_i,
  output logic      [OUT_COUNT-1:0]  dout_o,
  // per-axis function results
  output logic      [AXIS_COUNT-1:0] axis_fwd_limit_o,
  output logic      [AXIS_COUNT-1:0] axis_rev_limit_o,
  output logic      [AXIS_COUNT-1:0] axis_home_o,
  output logic      [AXIS_COUNT-1:0] axis_drive_err_o,
  output logic      [AXIS_COUNT-1:0] axis_stop_o,
  // interrupt
  output logic                       irq_o
);

  localparam int unsigned SCAN_W = $clog2(SCAN_CYCLES);
  localparam logic [SCAN_W-1:0] SCAN_LAST = SCAN_W'(SCAN_CYCLES - 1);

  // configuration registers
  logic [IN_COUNT-1:0]            input_trigger_kind_select_q;  // 1 = edge
  logic [IN_COUNT-1:0]            input_polarity_select_q;      // 1 = active high
  logic [IN_COUNT-1:0]            input_rising_edge_select_q;
  logic [IN_COUNT-1:0]            input_falling_edge_select_q;
  logic [IN_COUNT-1:0]            irq_mask_q;                   // 1 = enabled
  logic [OUT_COUNT*OMODE_W-1:0]   out_mode_q;                   // source per output
  logic [OUT_COUNT*AXIS_COUNT-1:0] out_axes_q;                  // axis set per output
  logic [OUT_COUNT-1:0]           out_value_q;                  // general output value
  logic [OUT_COUNT-1:0]           output_polarity_select_q;     // 1 = active low
  logic [DATA_W-1:0]              axis_map_q [AXIS_COUNT];      // function map per axis

  // status
  logic [IN_COUNT-1:0]            pending_q;   // sticky edge flags
  logic [IN_COUNT-1:0]            pending_d;
  logic [IN_COUNT-1:0]            edge_set;    // qualifying edges this cycle
  logic [IN_COUNT-1:0]            wr_clear;    // write-one-to-clear mask

  // scan timing
  logic [SCAN_W-1:0]              scan_cnt_q;
  logic                           scan_tick_q;

  // sampled inputs
  logic [IN_COUNT-1:0]            in_level;
  logic [IN_COUNT-1:0]            in_rise;
  logic [IN_COUNT-1:0]            in_fall;
  logic [IN_COUNT-1:0]            in_active;

  // output source values before polarity
  logic [OUT_COUNT-1:0]           out_pre;

  // strobes qualified by the clock enable
  logic                           wr_en;
  logic                           rd_en;

  assign wr_en = we_i & ce_i;
  assign rd_en = re_i & ce_i;

  // scan timer: one tick every scan period
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      scan_cnt_q  <= '0;
      scan_tick_q <= 1'b0;
    end else if (ce_i) begin
      scan_tick_q <= (scan_cnt_q == SCAN_LAST);                       // [RULE8]
      if (scan_cnt_q == SCAN_LAST) begin
        scan_cnt_q <= '0;
      end else begin
        scan_cnt_q <= scan_cnt_q + SCAN_W'(1);
      end
    end
  end

  // one sampler per input pin
  for (genvar i = 0; i < IN_COUNT; i++) begin : g_in
    mio_in_sampler u_samp (
      .clk_i       (clk_i),
      .rst_b_i     (rst_b_i),
      .ce_i        (ce_i),
      .scan_tick_i (scan_tick_q),
      .pin_i       (din_i[i]),
      .level_o     (in_level[i]),
      .rise_o      (in_rise[i]),
      .fall_o      (in_fall[i])
    );
  end

  // qualifying edges and the active view of every input
  always_comb begin
    edge_set  = input_trigger_kind_select_q &
                ((in_rise & input_rising_edge_select_q) |
                 (in_fall & input_falling_edge_select_q));            // [RULE4]
    in_active = (input_trigger_kind_select_q & pending_q) |
                (~input_trigger_kind_select_q &
                 ~(in_level ^ input_polarity_select_q));              // [RULE4]
    wr_clear  = (wr_en && addr_i == REG_PENDING) ? wdata_i[IN_COUNT-1:0] : '0;
    pending_d = (pending_q & ~wr_clear) | edge_set;                   // [RULE10]
  end

  // sticky edge flags; a new edge wins over a clear
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pending_q <= '0;
    end else if (ce_i) begin
      pending_q <= pending_d;                                         // [RULE10]
    end
  end

  // input configuration writes
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      input_trigger_kind_select_q <= '0;
      input_polarity_select_q     <= '1;
      input_rising_edge_select_q  <= '0;
      input_falling_edge_select_q <= '0;
      irq_mask_q                  <= '0;
    end else if (wr_en) begin
      if (addr_i == REG_TRIG_KIND) begin
        input_trigger_kind_select_q <= wdata_i[IN_COUNT-1:0];        // [RULE4]
      end else if (addr_i == REG_IN_POL) begin
        input_polarity_select_q <= wdata_i[IN_COUNT-1:0];            // [RULE4]
      end else if (addr_i == REG_RISE_SEL) begin
        input_rising_edge_select_q <= wdata_i[IN_COUNT-1:0];
      end else if (addr_i == REG_FALL_SEL) begin
        input_falling_edge_select_q <= wdata_i[IN_COUNT-1:0];
      end else if (addr_i == REG_IRQ_MASK) begin
        irq_mask_q <= wdata_i[IN_COUNT-1:0];
      end
    end
  end

  // output configuration writes
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      out_mode_q               <= '0;
      out_axes_q               <= '0;
      out_value_q              <= '0;
      output_polarity_select_q <= '0;                                 // [RULE9]
    end else if (wr_en) begin
      if (addr_i == REG_OUT_MODE) begin
        out_mode_q <= wdata_i[OUT_COUNT*OMODE_W-1:0];                 // [RULE5]
      end else if (addr_i == REG_OUT_AXES) begin
        out_axes_q <= wdata_i[OUT_COUNT*AXIS_COUNT-1:0];              // [RULE6]
      end else if (addr_i == REG_OUT_VALUE) begin
        out_value_q <= wdata_i[OUT_COUNT-1:0];                        // [RULE1]
      end else if (addr_i == REG_OUT_POL) begin
        output_polarity_select_q <= wdata_i[OUT_COUNT-1:0];           // [RULE7]
      end
    end
  end

  // per-axis function map writes, one word per axis
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      for (int a = 0; a < AXIS_COUNT; a++) begin
        axis_map_q[a] <= RST_WORD;
      end
    end else if (wr_en) begin
      for (int a = 0; a < AXIS_COUNT; a++) begin
        if (addr_i == REG_AXIS_MAP0 + ADDR_W'(4 * a)) begin
          axis_map_q[a] <= wdata_i;                                   // [RULE2]
        end
      end
    end
  end

  // one mapped function: enabled and the indexed input is active
  function automatic logic fn_hit(input logic [DATA_W-1:0]   map,
                                  input int unsigned         pos,
                                  input logic [IN_COUNT-1:0] act);
    logic [FN_IDX_W-1:0] idx;
    idx    = map[pos +: FN_IDX_W];
    fn_hit = map[pos + FN_EN_BIT] & act[idx];
  endfunction : fn_hit

  // per-axis function results; each axis reads its own index
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      axis_fwd_limit_o <= '0;
      axis_rev_limit_o <= '0;
      axis_home_o      <= '0;
      axis_drive_err_o <= '0;
      axis_stop_o      <= '0;
    end else if (ce_i) begin
      for (int a = 0; a < AXIS_COUNT; a++) begin
        axis_fwd_limit_o[a] <= fn_hit(axis_map_q[a], FN_FWD, in_active);   // [RULE2] [RULE3]
        axis_rev_limit_o[a] <= fn_hit(axis_map_q[a], FN_REV, in_active);   // [RULE2]
        axis_home_o[a]      <= fn_hit(axis_map_q[a], FN_HOME, in_active);  // [RULE2] [RULE3]
        axis_drive_err_o[a] <= fn_hit(axis_map_q[a], FN_ERR, in_active);   // [RULE2]
        axis_stop_o[a]      <= fn_hit(axis_map_q[a], FN_STOP, in_active);  // [RULE2]
      end
    end
  end

  // output source selection
  always_comb begin
    for (int o = 0; o < OUT_COUNT; o++) begin
      case (out_mode_q[o*OMODE_W +: OMODE_W])
        OMODE_GENERAL: out_pre[o] = out_value_q[o];
        OMODE_DRIVE:   out_pre[o] = |(out_axes_q[o*AXIS_COUNT +: AXIS_COUNT]
                                      & axis_drive_en_i);             // [RULE5] [RULE6]
        OMODE_ERROR:   out_pre[o] = gen_error_i;                      // [RULE5]
        default:       out_pre[o] = 1'b0;
      endcase
    end
  end

  // output pins with active level applied; low after reset
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dout_o <= '0;                                                   // [RULE9]
    end else if (ce_i) begin
      dout_o <= out_pre ^ output_polarity_select_q;                   // [RULE7]
    end
  end

  // interrupt: any unmasked pending flag
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(pending_d & irq_mask_q);
    end
  end

  // read data, valid in the cycle after the strobe only
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rdata_o <= RST_WORD;
    end else if (ce_i) begin
      rdata_o <= RST_WORD;
      if (rd_en) begin
        if (addr_i == REG_IN_STATE) begin
          rdata_o[IN_COUNT-1:0] <= in_level;                          // [RULE1]
        end else if (addr_i == REG_IN_ACTIVE) begin
          rdata_o[IN_COUNT-1:0] <= in_active;
        end else if (addr_i == REG_TRIG_KIND) begin
          rdata_o[IN_COUNT-1:0] <= input_trigger_kind_select_q;
        end else if (addr_i == REG_IN_POL) begin
          rdata_o[IN_COUNT-1:0] <= input_polarity_select_q;
        end else if (addr_i == REG_RISE_SEL) begin
          rdata_o[IN_COUNT-1:0] <= input_rising_edge_select_q;
        end else if (addr_i == REG_FALL_SEL) begin
          rdata_o[IN_COUNT-1:0] <= input_falling_edge_select_q;
        end else if (addr_i == REG_PENDING) begin
          rdata_o[IN_COUNT-1:0] <= pending_q;                         // [RULE10]
        end else if (addr_i == REG_IRQ_MASK) begin
          rdata_o[IN_COUNT-1:0] <= irq_mask_q;
        end else if (addr_i == REG_OUT_MODE) begin
          rdata_o[OUT_COUNT*OMODE_W-1:0] <= out_mode_q;
        end else if (addr_i == REG_OUT_AXES) begin
          rdata_o[OUT_COUNT*AXIS_COUNT-1:0] <= out_axes_q;
        end else if (addr_i == REG_OUT_VALUE) begin
          rdata_o[OUT_COUNT-1:0] <= out_value_q;
        end else if (addr_i == REG_OUT_POL) begin
          rdata_o[OUT_COUNT-1:0] <= output_polarity_select_q;
        end else if (addr_i == REG_AXIS_MAP0) begin
          rdata_o <= axis_map_q[0];
        end else if (addr_i == REG_AXIS_MAP1) begin
          rdata_o <= axis_map_q[1];
        end else if (addr_i == REG_AXIS_MAP2) begin
          rdata_o <= axis_map_q[2];
        end else if (addr_i == REG_AXIS_MAP3) begin
          rdata_o <= axis_map_q[3];
        end
      end
    end
  end

  // helpers read only by the checks below
  logic ax0_fwd_exp;
  logic ax01_home_same;
  logic out0_drive_exp;
  // written out apart from fn_hit so the check does not share its logic
  assign ax0_fwd_exp    = axis_map_q[0][FN_FWD + FN_EN_BIT] & in_active[axis_map_q[0][FN_FWD +: FN_IDX_W]];
  assign out0_drive_exp = (|(out_axes_q[AXIS_COUNT-1:0] & axis_drive_en_i)) ^ output_polarity_select_q[0];
  assign ax01_home_same = axis_map_q[0][FN_HOME + FN_EN_BIT] & axis_map_q[1][FN_HOME + FN_EN_BIT] &
                          (axis_map_q[0][FN_HOME +: FN_IDX_W] == axis_map_q[1][FN_HOME +: FN_IDX_W]);

  in_state_read_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (rd_en && addr_i == REG_IN_STATE) |=> rdata_o[IN_COUNT-1:0] == $past(in_level))  // [RULE1]
    else $error("input state read mismatch");

  fwd_limit_map_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i |=> axis_fwd_limit_o[0] == $past(ax0_fwd_exp))  // [RULE2]
    else $error("axis 0 forward limit wrong");

  shared_home_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && ax01_home_same) |=> axis_home_o[0] == axis_home_o[1])  // [RULE3]
    else $error("shared home input differs between axes");

  edge_pend_set_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && input_trigger_kind_select_q[0] && in_rise[0] && input_rising_edge_select_q[0])
      |=> pending_q[0])  // [RULE4]
    else $error("rising edge did not set pending");

  drive_share_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && out_mode_q[OMODE_W-1:0] == OMODE_DRIVE)
      |=> dout_o[0] == $past(out0_drive_exp))  // [RULE6]
    else $error("drive enable output wrong");

  out_polarity_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ce_i |=> dout_o == ($past(out_pre) ^ $past(output_polarity_select_q)))  // [RULE7]
    else $error("output polarity not applied");

  scan_period_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (ce_i && scan_cnt_q == SCAN_LAST) |=> scan_tick_q && scan_cnt_q == '0)  // [RULE8]
    else $error("scan tick out of step");

  reset_out_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(rst_b_i) |-> (dout_o == '0 && irq_o == 1'b0))  // [RULE9]
    else $error("outputs active after reset");

  pend_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (pending_q[0] && !wr_clear[0]) |=> pending_q[0])  // [RULE10]
    else $error("pending flag lost without clear");

endmodule : mio_top
`default_nettype wire

/* verification/mio_field_model.sv */
`timescale 1ns/1ps
`default_nettype none
// switches and sensors at the input pins: each new level is held
// for at least one scan so the block cannot miss it
module mio_field_model
  import mio_pkg::*;
#(
  parameter int unsigned HOLD = 16  // minimum cycles a level stands
) (
  // clock
  input  wire logic                clk_i,
  // requested pin levels
  input  wire logic [IN_COUNT-1:0] want_i,
  // pins toward the block
  output logic      [IN_COUNT-1:0] din_o
);
  int unsigned held_q;  // cycles since the last pin change

  initial din_o = '0;
  initial held_q = 0;

  // apply a new level only once the old one has stood long enough
  always @(posedge clk_i) begin
    if (want_i != din_o && held_q >= HOLD) begin
      din_o  <= want_i;
      held_q <= 0;
    end else if (held_q < HOLD) begin
      held_q <= held_q + 1;
    end
  end
endmodule : mio_field_model
`default_nettype wire

/* verification/test_mio_top.sv */
`timescale 1ns/1ps
`default_nettype none
module test_mio_top
  import mio_pkg::*;
();
  localparam int unsigned SCAN = 16;  // short scan for simulation
  // clock, reset and register port
  logic                  clk_i;
  logic                  rst_b_i;
  logic                  ce_i;
  logic                  we_i;
  logic                  re_i;
  logic [ADDR_W-1:0]     addr_i;
  logic [DATA_W-1:0]     wdata_i;
  logic [DATA_W-1:0]     rdata_o;
  // motion sources, pins, results
  logic [AXIS_COUNT-1:0] en_i;
  logic                  err_i;
  logic [IN_COUNT-1:0]   want;
  logic [IN_COUNT-1:0]   din;
  logic [OUT_COUNT-1:0]  dout;
  logic [AXIS_COUNT-1:0] ax_o [5];
  logic                  irq;
  // bench state
  logic [31:0]           amap [4];
  logic [31:0]           v;
  logic [15:0]           pol, rise, fall, old, pend, clr;
  logic [15:0]           omode;
  logic [31:0]           oaxes;
  logic [7:0]            oval, opol;
  int                    err_total = 0;
  int                    n_tests = 0;

  mio_top #(.SCAN_CYCLES(SCAN)) DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .ce_i(ce_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i), .re_i(re_i), .rdata_o(rdata_o),
    .axis_drive_en_i(en_i), .gen_error_i(err_i), .din_i(din), .dout_o(dout),
    .axis_fwd_limit_o(ax_o[0]), .axis_rev_limit_o(ax_o[1]), .axis_home_o(ax_o[2]),
    .axis_drive_err_o(ax_o[3]), .axis_stop_o(ax_o[4]), .irq_o(irq));

  mio_field_model #(.HOLD(SCAN)) field (.clk_i(clk_i), .want_i(want), .din_o(din));

  // 50 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // one-cycle write strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    we_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask : wr

  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    re_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1 d = rdata_o;
  endtask : rd

  // expected output pins from mode, sources and polarity
  function automatic logic [7:0] dout_exp(input logic [3:0] en, input logic er);
    logic [7:0] r;
    for (int j = 0; j < 8; j++) begin
      case (omode[2*j +: 2])
        2'h0: r[j] = oval[j];
        2'h1: r[j] = |(oaxes[4*j +: 4] & en);
        2'h2: r[j] = er;
        default: r[j] = 1'b0;
      endcase
      r[j] = r[j] ^ opol[j];
    end
    return r;
  endfunction : dout_exp

  // expected per-axis result of one function from active inputs
  function automatic logic [3:0] ax_exp(input int f, input logic [15:0] act);
    logic [3:0] r;
    for (int a = 0; a < 4; a++) begin
      r[a] = amap[a][f*FN_W + FN_EN_BIT] & act[amap[a][f*FN_W +: FN_IDX_W]];
    end
    return r;
  endfunction : ax_exp

  // all five functions on all axes
  task automatic chk_axes(input logic [15:0] act);
    for (int f = 0; f < 5; f++) begin
      chk({28'h0, ax_o[f]}, {28'h0, ax_exp(f, act)});
    end
  endtask : chk_axes

  task automatic finish_test();
    if (err_total == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  // watchdog against a hang
  initial begin
    repeat (40000) @(posedge clk_i);
    err_total++;
    finish_test();
  end

  initial begin
    rst_b_i = 1'b0;
    ce_i = 1'b1;
    we_i = 1'b0;
    re_i = 1'b0;
    addr_i = '0;
    wdata_i = '0;
    en_i = '0;
    err_i = 1'b0;
    want = '0;
    v = $urandom(32'h0B51BA58);
    repeat (5) @(posedge clk_i);
    rst_b_i <= 1'b1;
    // reset state and refused accesses
    #1 chk({24'h0, dout}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(REG_IN_POL, v);
    chk(v, 32'h0000_FFFF);
    wr(REG_IN_STATE, 32'h0000_FFFF);
    rd(REG_IN_STATE, v);
    chk(v, 32'h0);
    rd(8'h40, v);
    chk(v, 32'h0);
    @(posedge clk_i);
    ce_i <= 1'b0;
    wr(REG_OUT_VALUE, 32'h0000_00FF);
    ce_i <= 1'b1;
    rd(REG_OUT_VALUE, v);
    chk(v, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 chk({24'h0, dout}, 32'h0);
    // outputs in every mode with random sources
    for (int i = 0; i < 12; i++) begin
      omode = (i == 0) ? 16'h5555 : 16'($urandom);
      oaxes = (i == 0) ? 32'hFFFF_FFFF : $urandom;
      oval = 8'($urandom);
      opol = 8'($urandom);
      wr(REG_OUT_MODE, {16'h0, omode});
      wr(REG_OUT_AXES, oaxes);
      wr(REG_OUT_VALUE, {24'h0, oval});
      wr(REG_OUT_POL, {24'h0, opol});
      en_i <= 4'($urandom);
      err_i <= 1'($urandom);
      repeat (4) @(posedge clk_i);
      #1 chk({24'h0, dout}, {24'h0, dout_exp(en_i, err_i)});
    end
    // level-triggered inputs mapped to axis functions
    for (int i = 0; i < 8; i++) begin
      for (int a = 0; a < 4; a++) begin
        amap[a] = '0;
        for (int f = 0; f < 5; f++) begin
          amap[a][f*FN_W +: FN_W] = (i == 0) ? 5'h15 : 5'($urandom);
        end
        wr(REG_AXIS_MAP0 + 8'(4*a), amap[a]);
      end
      pol = 16'($urandom);
      wr(REG_IN_POL, {16'h0, pol});
      want <= (i == 1) ? 16'h0020 : 16'($urandom);
      repeat (3*SCAN + 8) @(posedge clk_i);
      rd(REG_IN_STATE, v);
      chk(v, {16'h0, want});
      rd(REG_IN_ACTIVE, v);
      chk(v, {16'h0, ~(want ^ pol)});
      chk_axes(~(want ^ pol));
    end
    // edge-triggered inputs with sticky flags and interrupt
    rise = 16'($urandom) | 16'h0001;  // bit 0 always armed for rising edges
    fall = 16'($urandom);
    wr(REG_TRIG_KIND, 32'h0000_FFFF);
    wr(REG_RISE_SEL, {16'h0, rise});
    wr(REG_FALL_SEL, {16'h0, fall});
    wr(REG_IRQ_MASK, 32'h0000_FFFF);
    wr(REG_PENDING, 32'h0000_FFFF);
    old = want;
    pend = '0;
    for (int i = 0; i < 8; i++) begin
      want <= (i == 0) ? ~old : 16'($urandom);
      repeat (3*SCAN + 8) @(posedge clk_i);
      pend = pend | (rise & ~old & want) | (fall & old & ~want);
      rd(REG_PENDING, v);
      chk(v, {16'h0, pend});
      chk({31'h0, irq}, {31'h0, |pend});
      chk_axes(pend);
      clr = 16'($urandom);
      wr(REG_PENDING, {16'h0, clr});
      pend = pend & ~clr;
      rd(REG_PENDING, v);
      chk(v, {16'h0, pend});
      old = want;
    end
    // shortest pulse the field sends: every input leaves and returns after one scan
    want <= ~old;
    repeat (2) @(posedge clk_i);
    want <= old;
    repeat (4*SCAN + 8) @(posedge clk_i);
    pend = pend | rise | fall;
    rd(REG_PENDING, v);
    chk(v, {16'h0, pend});
    wr(REG_IRQ_MASK, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 chk({31'h0, irq}, 32'h0);
    // mid-run reset: configured outputs drop to inactive at once
    @(posedge clk_i);
    rst_b_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    #1 chk({24'h0, dout}, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd(REG_PENDING, v);
    chk(v, 32'h0);
    repeat (2) @(posedge clk_i);
    #1 chk({24'h0, dout}, 32'h0);
    finish_test();
  end
endmodule : test_mio_top
`default_nettype wire
